// ### cdbg_defines.vh
`ifndef CDBG_DEFINES_VH
`define CDBG_DEFINES_VH

// ****************************************
// system operation encodings
// ****************************************
`define OP0_SYS 2'h1
`define OP1_IMPL 3'h6
`define CRN_IMPL 4'hf
`define CRM_CDBG 4'h4
`define OP2_L2_TLB_TWO 3'h2
`define OP2_L2_DATA 3'h3

// ****************************************
// argument fields
// ****************************************
`define ARG_WAY_HI 31
`define ARG_WAY_LO 29
`define ARG_SET_HI 15
`define ARG_SET_LO 6
`define ARG_OFS_HI 5
`define ARG_OFS_LO 3
`define ARG_TLB_SET_HI 9
`define ARG_TLB_SET_LO 0

// ****************************************
// exception levels and classes
// ****************************************
`define EL_APP 2'h0
`define EL_KERNEL 2'h1
`define EL_HYP 2'h2
`define EL_MONITOR 2'h3
`define EC_SYS_TRAP 6'h18

// ****************************************
// tlb entry slice placed in the result
// ****************************************
`define TLB_SLICE_LO 128
`define TLB_SLICE_HI 191
`define RESULT_RESET 64'h0
`define OFS_RESET 3'h0
`define CLASS_RESET 6'h0

`endif

// ### cdbg_index_clamp.v
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// folds an out-of-range set/way onto one valid entry
// ****************************************
module cdbg_index_clamp #(
    parameter WAY_W = 3,
    parameter SET_W = 10,
    parameter NUM_WAYS = 8,
    parameter NUM_SETS = 1024
) (
    // requested location
    input wire [WAY_W-1:0] way_in,
    input wire [SET_W-1:0] set_in,
    // location actually read
    output wire [WAY_W-1:0] way_out,
    output wire [SET_W-1:0] set_out
);

    wire way_ok;
    wire set_ok;

    assign way_ok = ({1'b0, way_in} < NUM_WAYS);
    assign set_ok = ({1'b0, set_in} < NUM_SETS);
    // beyond range: read entry zero, a single arbitrary line
    assign way_out = (way_ok && set_ok) ? way_in : {WAY_W{1'b0}};
    assign set_out = (way_ok && set_ok) ? set_in : {SET_W{1'b0}};

endmodule
`default_nettype wire

// ### cdbg_read_unit.v
// Function
// [R1] l2 data read yields 64 bits
// [R2] data argument: way, set, offset fields
// [R3] oversized data set/way reads one arbitrary line
// [R4] oversized tlb set/way reads one arbitrary entry
// [R5] decode l2 data read encoding
// [R6] decode l2 tlb read two encoding
// [R7] application level issue is undefined
// [R8] kernel level traps if enabled, else undefined
// [R9] hypervisor level issue is undefined
// [R10] only monitor level performs the read
// [R11] tlb read two returns bits 191:128
// [R12] result holds until next read completes
`timescale 1ns/10ps
`default_nettype none
`include "cdbg_defines.vh"

module cdbg_read_unit #(
    parameter WAY_W = 3,
    parameter SET_W = 10,
    parameter NUM_WAYS = 8,
    parameter NUM_SETS = 1024,
    parameter TLB_WAYS = 8,
    parameter TLB_SETS = 1024
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // system instruction issue
    input wire op_valid,
    input wire [1:0] op0,
    input wire [2:0] op1,
    input wire [3:0] crn,
    input wire [3:0] crm,
    input wire [2:0] op2,
    input wire [63:0] op_arg,
    // privilege state
    input wire [1:0] current_exception_level,
    input wire hyp_enabled,
    input wire trap_impl_defined_ops,
    // l2 data memory port
    output reg mem_rd_r,
    output reg [WAY_W-1:0] mem_way_r,
    output reg [SET_W-1:0] mem_set_r,
    output reg [2:0] mem_ofs_r,
    input wire mem_rvalid,
    input wire [63:0] mem_rdata,
    // l2 tlb port
    output reg tlb_rd_r,
    output reg [WAY_W-1:0] tlb_way_r,
    output reg [SET_W-1:0] tlb_set_r,
    input wire tlb_rvalid,
    input wire [191:0] tlb_rdata,
    // outcome
    output reg undef_r,
    output reg trap_r,
    output reg [5:0] trap_class_r,
    output reg busy_r,
    output reg done_r,
    output reg [63:0] debug_read_result
);

    // ****************************************
    // states
    // ****************************************
    localparam ST_IDLE = 3'h1;
    localparam ST_MEM = 3'h2;
    localparam ST_TLB = 3'h4;

    reg [2:0] state_r;
    reg [2:0] state_nxt;

    // ****************************************
    // decode
    // ****************************************
    wire sys_prefix;
    wire is_data_op;
    wire is_tlb_op;
    wire is_cdbg;
    wire at_monitor;
    wire do_trap;
    wire do_undef;
    wire mem_done;
    wire tlb_done;
    wire [WAY_W-1:0] d_way;
    wire [SET_W-1:0] d_set;
    wire [WAY_W-1:0] t_way;
    wire [SET_W-1:0] t_set;

    assign sys_prefix = (op0 == `OP0_SYS) && (op1 == `OP1_IMPL) &&
        (crn == `CRN_IMPL) && (crm == `CRM_CDBG);
    assign is_data_op = sys_prefix && (op2 == `OP2_L2_DATA); // [R5]
    assign is_tlb_op = sys_prefix && (op2 == `OP2_L2_TLB_TWO); // [R6]
    assign is_cdbg = op_valid && (state_r == ST_IDLE) && (is_data_op || is_tlb_op);
    assign at_monitor = (current_exception_level == `EL_MONITOR); // [R10]
    assign do_trap = (current_exception_level == `EL_KERNEL) &&
        hyp_enabled && trap_impl_defined_ops; // [R8]
    // application, hypervisor, and untrapped kernel issue
    assign do_undef = !at_monitor && !do_trap; // [R7] [R9]
    // answer taken only while its read is pending
    assign mem_done = (state_r == ST_MEM) && mem_rvalid;
    assign tlb_done = (state_r == ST_TLB) && tlb_rvalid;

    // ****************************************
    // argument fields and range folding
    // ****************************************
    cdbg_index_clamp #(
        .WAY_W(WAY_W),
        .SET_W(SET_W),
        .NUM_WAYS(NUM_WAYS),
        .NUM_SETS(NUM_SETS)
    ) u_data_clamp (
        .way_in(op_arg[`ARG_WAY_HI:`ARG_WAY_LO]), // [R2]
        .set_in(op_arg[`ARG_SET_HI:`ARG_SET_LO]), // [R2]
        .way_out(d_way), // [R3]
        .set_out(d_set) // [R3]
    );

    cdbg_index_clamp #(
        .WAY_W(WAY_W),
        .SET_W(SET_W),
        .NUM_WAYS(TLB_WAYS),
        .NUM_SETS(TLB_SETS)
    ) u_tlb_clamp (
        .way_in(op_arg[`ARG_WAY_HI:`ARG_WAY_LO]),
        .set_in(op_arg[`ARG_TLB_SET_HI:`ARG_TLB_SET_LO]),
        .way_out(t_way), // [R4]
        .set_out(t_set) // [R4]
    );

    // ****************************************
    // next state
    // ****************************************
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (is_cdbg && at_monitor) begin
                    state_nxt = is_data_op ? ST_MEM : ST_TLB;
                end
            end
            ST_MEM: begin
                if (mem_rvalid) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_TLB: begin
                if (tlb_rvalid) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // registers
    // ****************************************
    always @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            mem_rd_r <= 1'b0;
            mem_way_r <= {WAY_W{1'b0}};
            mem_set_r <= {SET_W{1'b0}};
            mem_ofs_r <= `OFS_RESET;
            tlb_rd_r <= 1'b0;
            tlb_way_r <= {WAY_W{1'b0}};
            tlb_set_r <= {SET_W{1'b0}};
            undef_r <= 1'b0;
            trap_r <= 1'b0;
            trap_class_r <= `CLASS_RESET;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mem_rd_r <= 1'b0;
            tlb_rd_r <= 1'b0;
            undef_r <= 1'b0;
            trap_r <= 1'b0;
            done_r <= 1'b0;
            busy_r <= (state_nxt != ST_IDLE);
            if (is_cdbg && do_undef) begin
                undef_r <= 1'b1; // [R7] [R9]
            end
            if (is_cdbg && do_trap) begin
                trap_r <= 1'b1; // [R8]
                trap_class_r <= `EC_SYS_TRAP; // [R8]
            end
            if (is_cdbg && at_monitor && is_data_op) begin
                mem_rd_r <= 1'b1; // [R10]
                mem_way_r <= d_way; // [R3]
                mem_set_r <= d_set;
                mem_ofs_r <= op_arg[`ARG_OFS_HI:`ARG_OFS_LO]; // [R2]
            end
            if (is_cdbg && at_monitor && is_tlb_op) begin
                tlb_rd_r <= 1'b1; // [R10]
                tlb_way_r <= t_way; // [R4]
                tlb_set_r <= t_set;
            end
            if (mem_done || tlb_done) begin
                done_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // result register
    // ****************************************
    always @(posedge clk) begin
        if (rst) begin
            debug_read_result <= `RESULT_RESET;
        end else begin
            if (mem_done) begin
                debug_read_result <= mem_rdata; // [R1]
            end
            if (tlb_done) begin
                debug_read_result <= tlb_rdata[`TLB_SLICE_HI:`TLB_SLICE_LO]; // [R11]
            end
            // otherwise result holds [R12]
        end
    end

endmodule
`default_nettype wire

// ### cdbg_read_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "cdbg_defines.vh"
module cdbg_read_chk #(parameter NUM_WAYS = 8, parameter NUM_SETS = 1024) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // issue
    input wire logic op_valid,
    input wire logic [1:0] op0,
    input wire logic [2:0] op1,
    input wire logic [3:0] crn,
    input wire logic [3:0] crm,
    input wire logic [2:0] op2,
    input wire logic [63:0] op_arg,
    // privilege
    input wire logic [1:0] current_exception_level,
    input wire logic hyp_enabled,
    input wire logic trap_impl_defined_ops,
    // data memory
    input wire logic mem_rd_r,
    input wire logic [2:0] mem_way_r,
    input wire logic [9:0] mem_set_r,
    input wire logic [2:0] mem_ofs_r,
    input wire logic mem_rvalid,
    input wire logic [63:0] mem_rdata,
    // tlb
    input wire logic tlb_rd_r,
    input wire logic tlb_rvalid,
    input wire logic [191:0] tlb_rdata,
    // outcome
    input wire logic undef_r,
    input wire logic trap_r,
    input wire logic [5:0] trap_class_r,
    input wire logic busy_r,
    input wire logic done_r,
    input wire logic [63:0] debug_read_result
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire [1:0] el = current_exception_level;
    wire [63:0] tlb_hi = tlb_rdata[191:128];
    wire enc = op0 == `OP0_SYS && op1 == `OP1_IMPL && crn == `CRN_IMPL && crm == `CRM_CDBG
        && (op2 == `OP2_L2_DATA || op2 == `OP2_L2_TLB_TWO);
    wire hit = op_valid && !busy_r && enc;
    wire fit = op_arg[31:29] < NUM_WAYS && op_arg[15:6] < NUM_SETS;
    wire kt = hyp_enabled && trap_impl_defined_ops;
    logic is_data_r;
    logic [15:0] loc_r;
    // expected location of a taken read
    always_ff @(posedge clk) begin
        if (hit) begin
            is_data_r <= op2 == `OP2_L2_DATA;
            loc_r <= {fit ? {op_arg[31:29], op_arg[15:6]} : 13'h0, op_arg[5:3]};
        end
    end
    property p_app; hit && el == `EL_APP |=> undef_r && !trap_r && !mem_rd_r && !tlb_rd_r; endproperty
    a_app: assert property (p_app) else $error("app level not undefined");
    property p_hyp; hit && el == `EL_HYP |=> undef_r && !trap_r && !mem_rd_r; endproperty
    a_hyp: assert property (p_hyp) else $error("hyp level not undefined");
    property p_ktrap; hit && el == `EL_KERNEL && kt |=> trap_r && !undef_r
        && trap_class_r == `EC_SYS_TRAP; endproperty
    a_ktrap: assert property (p_ktrap) else $error("kernel trap wrong");
    property p_kundef; hit && el == `EL_KERNEL && !kt |=> undef_r && !trap_r; endproperty
    a_kundef: assert property (p_kundef) else $error("kernel undef wrong");
    property p_data; hit && el == `EL_MONITOR && op2 == `OP2_L2_DATA |=> mem_rd_r && !tlb_rd_r
        && {mem_way_r, mem_set_r, mem_ofs_r} == loc_r; endproperty
    a_data: assert property (p_data) else $error("data read wrong");
    property p_tlb; hit && el == `EL_MONITOR && op2 == `OP2_L2_TLB_TWO |=> tlb_rd_r
        && !mem_rd_r && !undef_r; endproperty
    a_tlb: assert property (p_tlb) else $error("tlb read wrong");
    property p_mdone; busy_r && is_data_r && mem_rvalid |=> done_r && !busy_r
        && debug_read_result == $past(mem_rdata); endproperty
    a_mdone: assert property (p_mdone) else $error("data result wrong");
    property p_tdone; busy_r && !is_data_r && tlb_rvalid |=> done_r
        && debug_read_result == $past(tlb_hi); endproperty
    a_tdone: assert property (p_tdone) else $error("tlb result wrong");
    property p_hold; !$past(rst) && !done_r |-> $stable(debug_read_result); endproperty
    a_hold: assert property (p_hold) else $error("result changed");
    property p_noop; op_valid && !busy_r && !enc |=> !undef_r && !trap_r && !mem_rd_r
        && !tlb_rd_r; endproperty
    a_noop: assert property (p_noop) else $error("foreign op acted on");
    c_data: cover property (hit && el == `EL_MONITOR);
    c_trap: cover property (trap_r);
    c_done: cover property (done_r);
endmodule
bind cdbg_read_unit cdbg_read_chk #(.NUM_WAYS(NUM_WAYS), .NUM_SETS(NUM_SETS)) chk_inst (
    .clk, .rst, .op_valid, .hyp_enabled, .trap_impl_defined_ops, .op0, .current_exception_level,
    .op1, .op2, .mem_way_r, .mem_ofs_r, .crn, .crm, .op_arg, .mem_rdata, .debug_read_result,
    .mem_set_r, .mem_rd_r, .mem_rvalid, .tlb_rd_r, .tlb_rvalid, .undef_r, .trap_r, .busy_r,
    .done_r, .tlb_rdata, .trap_class_r);
`default_nettype wire

// ### tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "cdbg_defines.vh"
module tb;
    logic clk = 1'b0, rst = 1'b1, op_valid = 1'b0, mem_rvalid = 1'b0, tlb_rvalid = 1'b0;
    logic hyp_enabled = 1'b0, trap_impl_defined_ops = 1'b0, tr;
    logic [1:0] op0 = `OP0_SYS, current_exception_level = 2'h0;
    logic [2:0] op1 = `OP1_IMPL, op2 = 3'h0;
    logic [3:0] crn = `CRN_IMPL, crm = `CRM_CDBG;
    logic [63:0] op_arg = 64'h0, mem_rdata = 64'h0, last_res;
    logic [191:0] tlb_rdata = 192'h0;
    wire mem_rd_r, tlb_rd_r, undef_r, trap_r, busy_r, done_r;
    wire [2:0] mem_way_r, mem_ofs_r, tlb_way_r;
    wire [9:0] mem_set_r, tlb_set_r;
    wire [5:0] trap_class_r;
    wire [63:0] debug_read_result;
    int failures = 0, total_checks = 0;
    cdbg_read_unit #(.NUM_WAYS(4), .NUM_SETS(512), .TLB_WAYS(4), .TLB_SETS(512))
        cdbg_read_unit_inst (
        .clk, .rst, .op_valid, .op0, .op1, .crn, .crm, .op2, .op_arg, .current_exception_level,
        .hyp_enabled, .trap_impl_defined_ops, .mem_rd_r, .mem_way_r, .mem_set_r, .mem_ofs_r,
        .mem_rvalid, .mem_rdata, .tlb_rd_r, .tlb_way_r, .tlb_set_r, .tlb_rvalid, .tlb_rdata,
        .undef_r, .trap_r, .trap_class_r, .busy_r, .done_r, .debug_read_result);
    always #5 clk = ~clk;
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle issue pulse, returns just after the taking edge
    task automatic issue(input logic [1:0] l, input logic [3:0] m, input logic [2:0] o,
        input logic [63:0] a);
        @(posedge clk);
        op_valid <= 1'b1;
        current_exception_level <= l;
        crm <= m;
        op2 <= o;
        op_arg <= a;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [2:0] o, input logic [63:0] a, input logic [15:0] loc);
        logic [191:0] d;
        d = {a ^ 64'h0f0f0f0f0f0f0f0f, ~a, a ^ 64'h123456789abcdef0};
        issue(`EL_MONITOR, `CRM_CDBG, o, a);
        if (o == `OP2_L2_DATA) begin
            chk({mem_rd_r, mem_way_r, mem_set_r, mem_ofs_r}, {1'b1, loc});
        end else begin
            chk({tlb_rd_r, tlb_way_r, tlb_set_r, 3'h0}, {1'b1, loc});
        end
        chk(busy_r, 1'b1);
        issue(`EL_APP, `CRM_CDBG, o, a);
        chk({undef_r, busy_r}, 2'h1);
        @(posedge clk);
        mem_rdata <= d[63:0];
        tlb_rdata <= d;
        mem_rvalid <= o == `OP2_L2_DATA;
        tlb_rvalid <= o != `OP2_L2_DATA;
        @(posedge clk);
        mem_rvalid <= 1'b0;
        tlb_rvalid <= 1'b0;
        #1;
        last_res = (o == `OP2_L2_DATA) ? d[63:0] : d[191:128];
        chk({done_r, busy_r}, 2'h2);
        chk(debug_read_result, last_res);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`OP2_L2_DATA, 64'h000001004010296a, 16'h452d);
        rd(`OP2_L2_DATA, 64'h2000fff8, 16'h0007);
        rd(`OP2_L2_DATA, 64'ha00000c0, 16'h0000);
        rd(`OP2_L2_TLB_TWO, 64'h600011f0, 16'h6f80);
        rd(`OP2_L2_TLB_TWO, 64'h200003ff, 16'h0000);
        issue(`EL_MONITOR, 4'h3, `OP2_L2_DATA, 64'h0);
        chk({undef_r, trap_r, mem_rd_r, tlb_rd_r}, 4'h0);
        issue(`EL_MONITOR, `CRM_CDBG, 3'h1, 64'h0);
        chk({undef_r, trap_r, mem_rd_r, tlb_rd_r}, 4'h0);
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            hyp_enabled <= i[2];
            trap_impl_defined_ops <= i[1];
            issue(i[4:3], `CRM_CDBG, i[0] ? `OP2_L2_DATA : `OP2_L2_TLB_TWO, 64'h0);
            tr = i[4:3] == 2'h1 && i[2] && i[1];
            chk({undef_r, trap_r, tr ? trap_class_r : 6'h0},
                {!tr, tr, tr ? `EC_SYS_TRAP : 6'h0});
        end
        chk(debug_read_result, last_res);
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
